// ===== inc/fwp_consts.svh
// Purpose : named constants of the flash write protection block
// Assumes : included by its bare name from every design file
// Notes   : definitions only
`ifndef FWP_CONSTS_SVH
`define FWP_CONSTS_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define FWP_OPC_DYB_RD    8'hE0
`define FWP_OPC_DYB_WR    8'hE1
`define FWP_OPC_WRITE_ENABLE_CMD      8'h06
`define FWP_OPC_WRITE_DISABLE_CMD      8'h04
`define FWP_OPC_WRR       8'h01
`define FWP_OPC_PP        8'h02
`define FWP_OPC_QPP       8'h32
`define FWP_OPC_SE        8'hD8
`define FWP_OPC_BE        8'h60
`define FWP_OPC_ONETIME_BYTE_PROGRAM_CMD      8'h42
`define FWP_OPC_ONETIME_READ_CMD      8'h4B
`define FWP_OPC_RESET     8'hF0

// ----------------------------------------------------------------------
// dynamic lock byte values
// ----------------------------------------------------------------------
`define FWP_DYN_LOCKED    8'h00
`define FWP_DYN_OPEN      8'hFF

// ----------------------------------------------------------------------
// main array geometry
// ----------------------------------------------------------------------
`define FWP_NUM_SECT      256
`define FWP_SECT_LSB      16
`define FWP_ADDR_W        24

// ----------------------------------------------------------------------
// one-time space layout
// ----------------------------------------------------------------------
`define FWP_OTP_SIZE      24'h00_0400
`define FWP_OTP_REGIONS   32
`define FWP_OTP_REG_LSB   5
`define FWP_OTP_HALF_BIT  4
`define FWP_OTP_LOCK_LO   24'h00_0010
`define FWP_OTP_LOCK_HI   24'h00_0013
`define FWP_OTP_LOCK_INIT 32'hFFFF_FFFF

// ----------------------------------------------------------------------
// register write data layout: status in low byte, config in high byte
// ----------------------------------------------------------------------
`define FWP_SR_BP_LSB     2
`define FWP_CR_FREEZE     8
`define FWP_CR_RANGE_ORIGIN_SELECT     13

// ----------------------------------------------------------------------
// range bit codes and reset values
// ----------------------------------------------------------------------
`define FWP_BP_NONE       3'h0
`define FWP_BP_ALL        3'h7
`define FWP_BP_DIV_LOG    7
`define FWP_BP_RST        3'h0
`define FWP_TB_RST        1'b0

`endif

// ===== inc/fwp_pkg.sv
// Purpose : types shared by the flash write protection block
// Assumes : constants come from fwp_consts.svh
// Notes   : types only
package fwp_pkg;

   // -------------------------------------------------------------------
   // decoded command from the serial front end
   // -------------------------------------------------------------------
   typedef struct packed {
      logic        valid;   // one-cycle pulse: command complete
      logic [7:0]  opcode;  // command code
      logic [23:0] addr;    // byte address
      logic [15:0] data;    // first data bytes, low byte first
   } fwp_cmd_t;

   // -------------------------------------------------------------------
   // visible protection state
   // -------------------------------------------------------------------
   typedef struct packed {
      logic       write_enable_latch;
      logic       prog_error;
      logic       freeze;
      logic       range_origin_select;
      logic [2:0] range_size;
   } fwp_stat_t;

   // -------------------------------------------------------------------
   // command kinds
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE   = 4'b0000,
      OP_WRITE_ENABLE_CMD   = 4'b0001,
      OP_WRITE_DISABLE_CMD   = 4'b0010,
      OP_WRR    = 4'b0011,
      OP_PROG   = 4'b0100,
      OP_SERASE = 4'b0101,
      OP_BERASE = 4'b0110,
      OP_ONETIME_BYTE_PROGRAM_CMD   = 4'b0111,
      OP_ONETIME_READ_CMD   = 4'b1000,
      OP_DYB_RD = 4'b1001,
      OP_DYB_WR = 4'b1010,
      OP_RESET  = 4'b1011
   } fwp_op_t;

endpackage

// ===== logic/fwp_protect.sv
// Purpose : write protection logic of a serial flash device
// Assumes : commands arrive decoded, on clk, from the serial front end
// Notes   : sys_rst is the power-on reset, hw_rst the hardware reset
`include "fwp_consts.svh"

module fwp_protect
#(
   parameter int NUM_SECT = `FWP_NUM_SECT
)(
   // clock and resets
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      hw_rst,
   // decoded command from the serial front end
   input  wire fwp_pkg::fwp_cmd_t         cmd,
   // persistent lock bits, low means locked
   input  wire logic [NUM_SECT-1:0]       persistent_sector_lock,
   // protection state
   output fwp_pkg::fwp_stat_t             stat,
   // dynamic lock read answer
   output logic [7:0]                     lock_rd_data,
   output logic                           lock_rd_valid,
   // main array program and erase verdicts
   output logic                           array_go,
   output logic                           array_refuse,
   // one-time space verdicts
   output logic                           otp_prog_go,
   output logic                           otp_rd_go,
   output logic                           otp_rd_defined
);
   import fwp_pkg::*;

   localparam int SB = $clog2(NUM_SECT);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   logic                wel_r;       // write enable latch
   logic                freeze_r;    // range and one-time freeze
   logic [2:0]          bp_r;        // range size code
   logic                tb_r;        // range origin select
   logic                perr_r;      // program error flag
   logic [NUM_SECT-1:0] dyb_r;       // dynamic lock bits, 1 = open
   logic [31:0]         otp_lock_r;  // shadow of the four lock bytes
   logic [7:0]          rd_data_r;
   logic                rd_valid_r;
   logic                arr_go_r;
   logic                arr_ref_r;
   logic                otp_go_r;
   logic                otp_rd_r;
   logic                otp_def_r;

   // -------------------------------------------------------------------
   // command decode
   // -------------------------------------------------------------------
   fwp_op_t             op;          // kind of the completed command
   logic [SB-1:0]       sect;        // addressed sector
   logic                range_hit;   // sector inside protected range
   logic                dyb_sel;     // dynamic lock of addressed sector
   logic                sect_prot;   // addressed sector protected
   logic                any_prot;    // some sector protected
   logic                otp_in;      // address inside the one-time space
   logic [4:0]          region;      // one-time region index
   logic                otp_locked;  // addressed region locked
   logic                otp_lockbyte;// address hits the lock bytes

   always_comb
   begin
      op = OP_NONE;
      if (cmd.valid)
      begin
         case (cmd.opcode)
            `FWP_OPC_WRITE_ENABLE_CMD   : op = OP_WRITE_ENABLE_CMD;
            `FWP_OPC_WRITE_DISABLE_CMD   : op = OP_WRITE_DISABLE_CMD;
            `FWP_OPC_WRR    : op = OP_WRR;
            `FWP_OPC_PP     : op = OP_PROG;
            `FWP_OPC_QPP    : op = OP_PROG;
            `FWP_OPC_SE     : op = OP_SERASE;
            `FWP_OPC_BE     : op = OP_BERASE;
            `FWP_OPC_ONETIME_BYTE_PROGRAM_CMD   : op = OP_ONETIME_BYTE_PROGRAM_CMD;
            `FWP_OPC_ONETIME_READ_CMD   : op = OP_ONETIME_READ_CMD;
            `FWP_OPC_DYB_RD : op = OP_DYB_RD;
            `FWP_OPC_DYB_WR : op = OP_DYB_WR;
            `FWP_OPC_RESET  : op = OP_RESET;
            default         : op = OP_NONE;
         endcase
      end
   end

   assign sect = cmd.addr[`FWP_SECT_LSB +: SB];

   // range decode lives in its own module so it can be reused per bank
   fwp_range_map #(
      .SB          (SB)
   ) u_range (
      .size_code   (bp_r),
      .from_bottom (tb_r),
      .sector      (sect),
      .hit         (range_hit)
   );

   // -------------------------------------------------------------------
   // protection verdict of the addressed sector
   // -------------------------------------------------------------------
   assign dyb_sel   = dyb_r[sect];
   // either lock at zero, or the range, protects the sector
   assign sect_prot = range_hit | ~dyb_sel
                    | ~persistent_sector_lock[sect];
   // bulk erase touches every sector, so any protection blocks it
   assign any_prot  = (bp_r != `FWP_BP_NONE) | ~(&dyb_r)
                    | ~(&persistent_sector_lock);

   // -------------------------------------------------------------------
   // one-time space address checks
   // -------------------------------------------------------------------
   assign otp_in = (cmd.addr < `FWP_OTP_SIZE);
   assign region = cmd.addr[`FWP_OTP_REG_LSB +: 5];
   assign otp_lockbyte = (cmd.addr >= `FWP_OTP_LOCK_LO)
                       && (cmd.addr <= `FWP_OTP_LOCK_HI);

   always_comb
   begin
      // lowest region: only its upper half, which holds the lock bytes, is guarded
      if (region == 5'h0)
      begin
         otp_locked = cmd.addr[`FWP_OTP_HALF_BIT]
                    & ~otp_lock_r[0];
      end
      else
      begin
         otp_locked = ~otp_lock_r[region];
      end
   end

   // -------------------------------------------------------------------
   // write enable latch
   // -------------------------------------------------------------------
   // cleared on completion of every modifying command except a dynamic lock write, even refused ones
   always_ff @(posedge clk)
   begin
      if (sys_rst || hw_rst)
      begin
         wel_r <= 1'b0;
      end
      else if (op == OP_WRITE_ENABLE_CMD)
      begin
         wel_r <= 1'b1;
      end
      else if (op == OP_WRITE_DISABLE_CMD || op == OP_WRR || op == OP_PROG
               || op == OP_SERASE || op == OP_BERASE
               || op == OP_ONETIME_BYTE_PROGRAM_CMD || op == OP_RESET)
      begin
         wel_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // range bits, origin bit and freeze
   // -------------------------------------------------------------------
   // hardware reset leaves these alone: freeze only yields to power-on
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         bp_r     <= `FWP_BP_RST;
         tb_r     <= `FWP_TB_RST;
         freeze_r <= 1'b0;
      end
      else if (op == OP_WRR && wel_r)
      begin
         if (!freeze_r)
         begin
            bp_r <= cmd.data[`FWP_SR_BP_LSB +: 3];
            tb_r <= cmd.data[`FWP_CR_RANGE_ORIGIN_SELECT];
         end
         // once set the freeze bit only accepts ones
         freeze_r <= freeze_r | cmd.data[`FWP_CR_FREEZE];
      end
   end

   // -------------------------------------------------------------------
   // program error flag
   // -------------------------------------------------------------------
   // a frozen or locked in-range one-time program flags an error; a
   // program outside the space is dropped silently
   always_ff @(posedge clk)
   begin
      if (sys_rst || hw_rst)
      begin
         perr_r <= 1'b0;
      end
      else if (op == OP_ONETIME_BYTE_PROGRAM_CMD && wel_r && otp_in
               && (freeze_r || otp_locked))
      begin
         perr_r <= 1'b1;
      end
      else if (op == OP_RESET)
      begin
         perr_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // dynamic lock bits
   // -------------------------------------------------------------------
   // only the two documented byte values change a bit; others are
   // dropped so a corrupted byte cannot half-unlock a sector
   always_ff @(posedge clk)
   begin
      if (sys_rst || hw_rst || op == OP_RESET)
      begin
         dyb_r <= '1;
      end
      else if (op == OP_DYB_WR && wel_r)
      begin
         if (cmd.data[7:0] == `FWP_DYN_LOCKED)
         begin
            dyb_r[sect] <= 1'b0;
         end
         else if (cmd.data[7:0] == `FWP_DYN_OPEN)
         begin
            dyb_r[sect] <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // lock byte shadow
   // -------------------------------------------------------------------
   // programming can only clear bits, so the shadow is ANDed
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         otp_lock_r <= `FWP_OTP_LOCK_INIT;
      end
      else if (op == OP_ONETIME_BYTE_PROGRAM_CMD && wel_r && otp_in && !freeze_r
               && !otp_locked && otp_lockbyte)
      begin
         otp_lock_r[cmd.addr[1:0]*8 +: 8] <=
            otp_lock_r[cmd.addr[1:0]*8 +: 8] & cmd.data[7:0];
      end
   end

   // -------------------------------------------------------------------
   // dynamic lock read answer
   // -------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst || hw_rst)
      begin
         rd_data_r  <= `FWP_DYN_OPEN;
         rd_valid_r <= 1'b0;
      end
      else
      begin
         rd_valid_r <= (op == OP_DYB_RD);
         if (op == OP_DYB_RD)
         begin
            rd_data_r <= dyb_sel ? `FWP_DYN_OPEN
                                 : `FWP_DYN_LOCKED;
         end
      end
   end

   // -------------------------------------------------------------------
   // main array verdicts
   // -------------------------------------------------------------------
   // the one-time space has no erase path at all: erases go here only
   always_ff @(posedge clk)
   begin
      if (sys_rst || hw_rst)
      begin
         arr_go_r  <= 1'b0;
         arr_ref_r <= 1'b0;
      end
      else
      begin
         arr_go_r  <= 1'b0;
         arr_ref_r <= 1'b0;
         if ((op == OP_PROG || op == OP_SERASE) && wel_r)
         begin
            arr_go_r  <= !sect_prot;
            arr_ref_r <= sect_prot;
         end
         else if (op == OP_BERASE && wel_r)
         begin
            arr_go_r  <= !any_prot;
            arr_ref_r <= any_prot;
         end
      end
   end

   // -------------------------------------------------------------------
   // one-time space verdicts
   // -------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst || hw_rst)
      begin
         otp_go_r  <= 1'b0;
         otp_rd_r  <= 1'b0;
         otp_def_r <= 1'b0;
      end
      else
      begin
         // repeat programs to one address are allowed
         otp_go_r <= (op == OP_ONETIME_BYTE_PROGRAM_CMD) && wel_r && otp_in
                     && !freeze_r && !otp_locked;
         otp_rd_r <= (op == OP_ONETIME_READ_CMD);
         if (op == OP_ONETIME_READ_CMD)
         begin
            otp_def_r <= otp_in;
         end
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign stat.write_enable_latch  = wel_r;
   assign stat.prog_error          = perr_r;
   assign stat.freeze              = freeze_r;
   assign stat.range_origin_select = tb_r;
   assign stat.range_size          = bp_r;
   assign lock_rd_data   = rd_data_r;
   assign lock_rd_valid  = rd_valid_r;
   assign array_go       = arr_go_r;
   assign array_refuse   = arr_ref_r;
   assign otp_prog_go    = otp_go_r;
   assign otp_rd_go      = otp_rd_r;
   assign otp_rd_defined = otp_def_r;

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || hw_rst);

   AST_WRITE_ENABLE_CMD_SETS: assert property (
      (op == OP_WRITE_ENABLE_CMD) |=> wel_r ##1 (wel_r || $past(cmd.valid)))
      else $error("latch not set by write enable");

   AST_WEL_CLEARS: assert property (
      (op == OP_PROG || op == OP_SERASE || op == OP_BERASE
       || op == OP_WRR || op == OP_ONETIME_BYTE_PROGRAM_CMD || op == OP_WRITE_DISABLE_CMD) |=> !wel_r)
      else $error("latch not cleared after modifying command");

   // sampled reset in the antecedent: the disable condition has already
   // dropped when the release edge starts its attempt
   AST_FREEZE_STICKS: assert property (
      (freeze_r && !sys_rst) |=> freeze_r [*3])
      else $error("freeze bit dropped without power-on reset");

   AST_FROZEN_RANGE: assert property (
      (freeze_r && op == OP_WRR)
      |=> $stable(bp_r) && $stable(tb_r) && $stable(perr_r))
      else $error("frozen range bits changed or error set");

   AST_OTP_FROZEN_ERR: assert property (
      (op == OP_ONETIME_BYTE_PROGRAM_CMD && wel_r && otp_in && freeze_r)
      |=> perr_r && !otp_prog_go)
      else $error("frozen one-time program not flagged");

   AST_OTP_OUT_RANGE: assert property (
      (op == OP_ONETIME_BYTE_PROGRAM_CMD && !otp_in)
      |=> !otp_prog_go && (perr_r == $past(perr_r)))
      else $error("out of range one-time program acted");

   AST_DYB_READBACK: assert property (
      (op == OP_DYB_RD) |=> lock_rd_valid
      && (lock_rd_data == ($past(dyb_sel) ? `FWP_DYN_OPEN
                                          : `FWP_DYN_LOCKED)))
      else $error("dynamic lock read returned wrong byte");

   AST_PROT_REFUSED: assert property (
      ((op == OP_PROG || op == OP_SERASE) && wel_r && sect_prot)
      |=> array_refuse && !array_go)
      else $error("protected sector was not refused");

   AST_NO_BOTH: assert property (
      !(array_go && array_refuse) && !(array_go && otp_prog_go))
      else $error("conflicting verdicts");

   COV_DYB_LOCK_REFUSE: cover property (
      (op == OP_DYB_WR && cmd.data[7:0] == `FWP_DYN_LOCKED && wel_r)
      ##[1:20] array_refuse);
   COV_FREEZE_ERR: cover property (
      freeze_r && op == OP_ONETIME_BYTE_PROGRAM_CMD ##1 perr_r);
   COV_OTP_GRANT: cover property (otp_prog_go);
   COV_RANGE_BOTTOM: cover property (tb_r && array_refuse);

endmodule // fwp_protect

// ===== logic/fwp_range_map.sv
// Purpose : decide whether a sector lies in the range-protected area
// Assumes : SB sector index bits, SB at least 6
// Notes   : purely combinational
`include "fwp_consts.svh"

module fwp_range_map
#(
   parameter int SB = 8
)(
   // range settings
   input  wire logic [2:0]    size_code,
   input  wire logic          from_bottom,
   // sector under test
   input  wire logic [SB-1:0] sector,
   // result
   output logic               hit
);

   // -------------------------------------------------------------------
   // span of protected sectors, then compare against the chosen edge
   // -------------------------------------------------------------------
   logic [SB:0] span;     // number of protected sectors
   logic [SB:0] whole;    // sector count of the array
   logic [SB:0] sect_w;   // widened sector index

   always_comb
   begin
      whole  = (SB+1)'(1) << SB;
      sect_w = {1'b0, sector};
      // code 1 protects a 64th, each code above doubles it
      if (size_code == `FWP_BP_NONE)
      begin
         span = '0;
      end
      else if (size_code == `FWP_BP_ALL)
      begin
         span = whole;
      end
      else
      begin
         span = (SB+1)'(1) << (SB - `FWP_BP_DIV_LOG + int'(size_code));
      end
      // origin bit picks the bottom or the top of the array
      if (from_bottom)
      begin
         hit = (sect_w < span);
      end
      else
      begin
         hit = (sect_w >= (whole - span));
      end
   end

endmodule // fwp_range_map

// ===== verif/fwp_host.sv
// Purpose : host controller model issuing decoded flash commands
// Assumes : one command word per call, answer one cycle later
// Notes   : idle fields show inverted data so stale values never pass
module fwp_host
(
   // clock
   input  wire logic        clk,
   // command word toward the protection logic
   output fwp_pkg::fwp_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 100ps;
   import fwp_pkg::*;

   initial cmd = '0;

   // one command pulse; address travels with every command
   task automatic send(input logic [7:0] op, input logic [23:0] a,
                       input logic [15:0] d);
      @(posedge clk);
      cmd <= '{1'b1, op, a, d};
      @(posedge clk);
      // released fields: inverse of last value, valid low
      cmd <= {1'b0, ~cmd[47:0]};
      #1;
   endtask
endmodule // fwp_host

// ===== verif/tb_fwp_protect.sv
// Purpose : self-checking bench of the write protection logic
// Assumes : host model issues commands, outputs settle one cycle later
// Notes   : table rows first, then reset and freeze cases by hand
module tb_fwp_protect;
   timeunit 1ns;
   timeprecision 100ps;
   import fwp_pkg::*;

   typedef struct packed {
      logic        w;   // send write enable first
      logic [7:0]  op;
      logic [23:0] a;
      logic [15:0] d;
      logic [12:0] e;   // wel, error, go, refuse, otp go, lock byte
   } fwp_row_t;

   logic           clk = 1'b0;
   logic           sys_rst = 1'b1;
   logic           hw_rst = 1'b0;
   logic [255:0]   persistent_sector_lock = '1;
   fwp_cmd_t       cmd;
   fwp_stat_t      stat;
   logic [7:0]     rd_data;
   logic           rd_vld, go, refuse, otp_go, rd_go, rd_def;
   int             failures = 0;
   int             comparisons = 0;
   wire logic [12:0] seen = {stat.write_enable_latch, stat.prog_error,
                             go, refuse, otp_go, rd_data};

   fwp_row_t rows [25] = '{
      '{1'b0, 8'h06, 24'h00_0000, 16'h0000, 13'h10FF},
      '{1'b0, 8'h02, 24'h03_0000, 16'h0000, 13'h04FF},
      '{1'b1, 8'hE1, 24'h03_0000, 16'h0000, 13'h10FF},
      '{1'b0, 8'hE0, 24'h03_0000, 16'h0000, 13'h1000},
      '{1'b0, 8'h02, 24'h03_0000, 16'h0000, 13'h0200},
      '{1'b1, 8'hD8, 24'h04_0000, 16'h0000, 13'h0400},
      '{1'b1, 8'hE1, 24'h03_0000, 16'h00FF, 13'h1000},
      '{1'b0, 8'hE0, 24'h03_0000, 16'h0000, 13'h10FF},
      '{1'b0, 8'h60, 24'h00_0000, 16'h0000, 13'h04FF},
      '{1'b1, 8'h01, 24'h00_0000, 16'h0004, 13'h00FF},
      '{1'b1, 8'h02, 24'hFF_0000, 16'h0000, 13'h02FF},
      '{1'b1, 8'h32, 24'hFB_0000, 16'h0000, 13'h04FF},
      '{1'b1, 8'h01, 24'h00_0000, 16'h2004, 13'h00FF},
      '{1'b1, 8'hD8, 24'h03_0000, 16'h0000, 13'h02FF},
      '{1'b1, 8'hD8, 24'h04_0000, 16'h0000, 13'h04FF},
      '{1'b1, 8'h42, 24'h00_0020, 16'h0000, 13'h01FF},
      '{1'b1, 8'h42, 24'h00_0020, 16'h0000, 13'h01FF},
      '{1'b1, 8'h42, 24'h00_0400, 16'h0000, 13'h00FF},
      '{1'b1, 8'h42, 24'h00_0011, 16'h00FE, 13'h01FF},
      '{1'b1, 8'h42, 24'h00_0100, 16'h0000, 13'h08FF},
      '{1'b0, 8'hF0, 24'h00_0000, 16'h0000, 13'h00FF},
      '{1'b1, 8'h42, 24'h00_0010, 16'h00FE, 13'h01FF},
      '{1'b1, 8'h42, 24'h00_0012, 16'h0000, 13'h08FF},
      '{1'b1, 8'h04, 24'h00_0000, 16'h0000, 13'h08FF},
      '{1'b1, 8'h01, 24'h00_0000, 16'h0000, 13'h08FF}
   };

   fwp_host fwp_host_inst (.clk(clk), .cmd(cmd));

   fwp_protect #(.NUM_SECT(256)) fwp_protect_inst (
      .clk(clk), .sys_rst(sys_rst), .hw_rst(hw_rst), .cmd(cmd),
      .persistent_sector_lock(persistent_sector_lock), .stat(stat),
      .lock_rd_data(rd_data), .lock_rd_valid(rd_vld), .array_go(go),
      .array_refuse(refuse), .otp_prog_go(otp_go), .otp_rd_go(rd_go),
      .otp_rd_defined(rd_def));

   always #2 clk = ~clk;

   // one comparison, counted, reported at once on mismatch
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      comparisons++;
      if (got !== want)
      begin
         failures++;
         $display("[ERR] %0t seen %h want %h", $time, got, want);
      end
   endtask

   task automatic test_done;
      $display("TB: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // watchdog: bounded run, a hang counts as a mismatch
   initial
   begin
      repeat (5000) @(posedge clk);
      failures++;
      test_done;
   end

   initial
   begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      check(16'({stat, rd_data, rd_def}), 16'h01FE);
      foreach (rows[i])
      begin
         if (rows[i].w)
            fwp_host_inst.send(8'h06, 24'h00_0000, 16'h0000);
         fwp_host_inst.send(rows[i].op, rows[i].a, rows[i].d);
         check(16'(seen), 16'(rows[i].e));
         check(16'(rd_vld), 16'(rows[i].op == 8'hE0));
      end
      // persistent lock alone must refuse the sector
      @(posedge clk);
      persistent_sector_lock[5] <= 1'b0;
      fwp_host_inst.send(8'h06, 24'h00_0000, 16'h0000);
      fwp_host_inst.send(8'h02, 24'h05_0000, 16'h0000);
      check(16'({go, refuse}), 16'h0001);
      fwp_host_inst.send(8'h4B, 24'h00_03FF, 16'h0000);
      check(16'({rd_go, rd_def}), 16'h0003);
      fwp_host_inst.send(8'h4B, 24'h00_0400, 16'h0000);
      check(16'({rd_go, rd_def}), 16'h0002);
      // clear the error left by the lock-byte rows, so the frozen
      // one-time program below is what raises it again
      fwp_host_inst.send(8'hF0, 24'h00_0000, 16'h0000);
      check(16'(stat), 16'h0000);
      // freeze with range code 2, then try to move the range
      fwp_host_inst.send(8'h06, 24'h00_0000, 16'h0000);
      fwp_host_inst.send(8'h01, 24'h00_0000, 16'h0108);
      check(16'(stat), 16'h0012);
      fwp_host_inst.send(8'h06, 24'h00_0000, 16'h0000);
      fwp_host_inst.send(8'h01, 24'h00_0000, 16'h201C);
      check(16'(stat), 16'h0012);
      fwp_host_inst.send(8'h06, 24'h00_0000, 16'h0000);
      fwp_host_inst.send(8'h42, 24'h00_0020, 16'h0000);
      check(16'({otp_go, stat}), 16'h0032);
      // hardware reset keeps freeze, power-on reset clears it
      @(posedge clk);
      hw_rst <= 1'b1;
      @(posedge clk);
      hw_rst <= 1'b0;
      @(posedge clk);
      #1;
      check(16'(stat), 16'h0012);
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      check(16'(stat), 16'h0000);
      test_done;
   end
endmodule // tb_fwp_protect
